// File: core/fdc_params.svh
// constants for the fixed-disk command sequencer
//
// Contract
// [RULE1] a command starts as soon as its byte is written, no other trigger
// [RULE2] host must not write a command while in-progress or busy is set
// [RULE3] host loads all task parameters first, in any order, command last
// [RULE4] upper nibble selects restore, seek, read, write, scan id, format
// [RULE5] restore/seek low nibble: 0 is 35 us, n is n times 0.5 ms
// [RULE6] read/write bit 0: zero enables retries, one disables them
// [RULE7] read bit 3: zero interrupts on buffer ready, one at completion
// [RULE8] restore steps outward; no track zero after 1024 steps sets error 1
// [RULE9] restore/seek save their rate for implied seeks; default is 7.5 ms
// [RULE10] seek steps the cylinder difference to the stored position, then ends
// [RULE11] host issues read, write and format only once busy has cleared
// [RULE12] read checks cylinder, seeks if needed, searches matching id field
// [RULE13] read raises data request, interrupt at end; ack strobe clears it
// [RULE14] multi flag repeats per sector, count down, number up, end at zero
// [RULE15] write requests buffer load, finds id, writes, interrupts at end
// [RULE16] write errors interrupt before buffer load; status bit 0 means error; code: only not-ready/fault aborts come before the load
// [RULE17] scan id loads head, size, number, cylinder and the position
// [RULE18] format: precomp is track/4, count sectors, number is gap minus 3
// [RULE19] format table: two bytes per sector, 80h bad or 00h, then number
// [RULE20] format loops until count is zero, interrupts, never errors
// [RULE21] control bit 7 drives the activity lamp: zero on, one off
// [RULE22] an undefined command code sets error bit 2, aborted
// [RULE23] in-progress holds during a command; error clears on new command
// [RULE24] command writes during a running command are ignored
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH

`define FDC_CLK_PERIOD_NS 4
`define FDC_STEP_FAST_NS 35000
`define FDC_STEP_UNIT_NS 500000
`define FDC_STEP_FAST_CYC (`FDC_STEP_FAST_NS / `FDC_CLK_PERIOD_NS)
`define FDC_STEP_UNIT_CYC (`FDC_STEP_UNIT_NS / `FDC_CLK_PERIOD_NS)
`define FDC_RESTORE_STEPS 1024
`define FDC_RETRY_LIMIT 3
`define FDC_RATE_DEFAULT 4'hf

// command byte fields
`define FDC_CMD_RETRY_OFF 0
`define FDC_CMD_MULTI 2
`define FDC_CMD_IRQ_END 3

// status bits
`define FDC_ST_ERR 0
`define FDC_ST_CIP 1
`define FDC_ST_DRQ 3
`define FDC_ST_SEEKDONE 4
`define FDC_ST_FAULT 5
`define FDC_ST_READY 6
`define FDC_ST_BUSY 7

// error bits
`define FDC_ER_NOTRK0 1
`define FDC_ER_ABORT 2
`define FDC_ER_IDNF 4
`define FDC_ER_DATA 6

`endif

// File: core/fdc_pkg.sv
// types shared by the fixed-disk command sequencer
package fdc_pkg;

  // upper nibble of the command byte
  typedef enum logic [3:0] {
    FDC_OP_RESTORE = 4'h1,
    FDC_OP_READ = 4'h2,
    FDC_OP_WRITE = 4'h3,
    FDC_OP_SCAN = 4'h4,
    FDC_OP_FORMAT = 4'h5,
    FDC_OP_SEEK = 4'h7
  } fdc_op_t;

  typedef enum logic [7:0] {
    FDC_IDLE = 8'h01,
    FDC_CALC = 8'h02,
    FDC_STEP = 8'h04,
    FDC_SETTLE = 8'h08,
    FDC_SEARCH = 8'h10,
    FDC_DISK = 8'h20,
    FDC_HOST = 8'h40,
    FDC_DONE = 8'h80
  } fdc_state_t;

  // task file contents as the sequencer sees them
  typedef struct packed {
    logic [7:0] precomp;
    logic [7:0] sec_cnt;
    logic [7:0] sec_num;
    logic [9:0] cyl;
    logic [1:0] size;
    logic [3:0] head;
  } fdc_task_t;

  // request levels to the read/write channel
  typedef struct packed {
    logic search;
    logic read;
    logic write;
    logic format;
  } fdc_chan_req_t;

endpackage : fdc_pkg

// File: core/fdc_step_timer.sv
// step interval timer for the fixed-disk command sequencer
`timescale 1ns/1ps
module fdc_step_timer #(
  parameter int unsigned FAST_CYC = 8750,
  parameter int unsigned UNIT_CYC = 125000
)(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic start, // pulse: begin one interval
  input wire logic [3:0] rate, // step rate code
  output logic done // pulse: interval elapsed
);

  logic [20:0] count;
  logic running;

  // code zero is the fast rate, every other code a multiple of half a ms
  function automatic logic [20:0] interval(input logic [3:0] code);
    if (code == 4'h0)
      return 21'(FAST_CYC); // [RULE5]
    else
      return 21'(code) * 21'(UNIT_CYC); // [RULE5]
  endfunction : interval

  // down counter; a new start restarts the interval
  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (sys_rst)
    begin
      count <= 21'h0;
      running <= 1'b0;
    end
    else if (start)
    begin
      count <= interval(rate) - 21'h1;
      running <= 1'b1;
    end
    else if (running)
    begin
      if (count == 21'h0)
      begin
        running <= 1'b0;
        done <= 1'b1;
      end
      else
        count <= count - 21'h1;
    end
  end

endmodule : fdc_step_timer

// File: core/fdc_sequencer.sv
// command sequencer of the fixed-disk controller
`timescale 1ns/1ps
`include "fdc_params.svh"
module fdc_sequencer #(
  parameter int unsigned STEP_FAST_CYC = `FDC_STEP_FAST_CYC,
  parameter int unsigned STEP_UNIT_CYC = `FDC_STEP_UNIT_CYC,
  parameter int unsigned RESTORE_STEPS = `FDC_RESTORE_STEPS,
  parameter int unsigned RETRIES = `FDC_RETRY_LIMIT
)(
  input wire logic sys_clk, // system clock, 250 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic cmd_wr, // pulse: command byte written
  input wire logic [7:0] cmd_byte, // disk_command_byte value
  input wire fdc_pkg::fdc_task_t task_in, // task file as loaded by host
  input wire logic buffer_ready, // pulse: host moved a sector
  input wire logic disk_interrupt_ack_strobe, // pulse: interrupt ack
  input wire logic led_select, // control register bit 7
  input wire logic track0_pin, // drive: head at track zero
  input wire logic drive_ready_pin, // drive: ready
  input wire logic drive_fault_pin, // drive: write fault
  input wire logic id_found, // pulse: matching id field seen
  input wire fdc_pkg::fdc_task_t id_fields, // fields of that id
  input wire logic id_error, // pulse: id not found or id crc
  input wire logic sector_done, // pulse: data field finished
  input wire logic data_error, // pulse: data field error
  output logic [7:0] status, // status byte
  output logic [7:0] error_flags, // error byte
  output logic buffer_data_request, // host may move buffer data
  output logic disk_irq, // interrupt request, level
  output logic step_pulse, // one-cycle step to drive
  output logic step_dir_in, // 1 steps inward
  output logic drive_led_on, // activity lamp lit
  output fdc_pkg::fdc_task_t task_out, // working task file
  output logic task_update, // pulse: task_out changed by a transfer or scan id
  output fdc_pkg::fdc_chan_req_t chan_req // request to the channel
);

  fdc_pkg::fdc_state_t state;
  fdc_pkg::fdc_op_t op;
  logic [3:0] mods; // low nibble of the running command
  logic [3:0] rate_q; // saved step rate
  logic [9:0] cur_cyl; // where the head is believed to be
  logic [10:0] steps_left;
  logic [2:0] retry_cnt;
  logic cip;
  logic busy;
  logic drq;
  logic seek_done;
  logic ev_irq;
  logic timer_start;
  logic timer_done;
  logic [2:0] trk0_s;
  logic [2:0] rdy_s;
  logic [2:0] flt_s;
  logic track0;
  logic drive_ready;
  logic drive_fault;

  // true when the transfer just finished was the last one
  function automatic logic last_sector(input fdc_pkg::fdc_op_t o,
                                       input logic [3:0] m,
                                       input logic [7:0] cnt);
    if (o != fdc_pkg::FDC_OP_FORMAT && !m[`FDC_CMD_MULTI])
      return 1'b1; // [RULE14]
    else
      return cnt == 8'h01; // [RULE14] [RULE20]
  endfunction : last_sector

  // retry allowed while the retry bit is clear and the budget lasts
  function automatic logic may_retry(input logic [3:0] m,
                                     input logic [2:0] n);
    return !m[`FDC_CMD_RETRY_OFF] && (32'(n) < RETRIES); // [RULE6]
  endfunction : may_retry

  fdc_step_timer #(
    .FAST_CYC(STEP_FAST_CYC),
    .UNIT_CYC(STEP_UNIT_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(timer_start),
    .rate(rate_q),
    .done(timer_done)
  );

  // drive pins arrive unclocked; a level counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      trk0_s <= 3'h0;
      rdy_s <= 3'h0;
      flt_s <= 3'h0;
      track0 <= 1'b0;
      drive_ready <= 1'b0;
      drive_fault <= 1'b0;
    end
    else
    begin
      trk0_s <= {trk0_s[1:0], track0_pin};
      rdy_s <= {rdy_s[1:0], drive_ready_pin};
      flt_s <= {flt_s[1:0], drive_fault_pin};
      if (trk0_s[2] == trk0_s[1])
        track0 <= trk0_s[2];
      if (rdy_s[2] == rdy_s[1])
        drive_ready <= rdy_s[2];
      if (flt_s[2] == flt_s[1])
        drive_fault <= flt_s[2];
    end
  end

  // main command sequence
  always_ff @(posedge sys_clk)
  begin
    step_pulse <= 1'b0;
    timer_start <= 1'b0;
    task_update <= 1'b0;
    ev_irq <= 1'b0;
    if (sys_rst)
    begin
      state <= fdc_pkg::FDC_IDLE;
      op <= fdc_pkg::FDC_OP_RESTORE;
      mods <= 4'h0;
      rate_q <= `FDC_RATE_DEFAULT; // [RULE9]
      cur_cyl <= 10'h0;
      steps_left <= 11'h0;
      retry_cnt <= 3'h0;
      cip <= 1'b0;
      busy <= 1'b0;
      drq <= 1'b0;
      seek_done <= 1'b0;
      step_dir_in <= 1'b0;
      error_flags <= 8'h0;
      task_out <= '0;
    end
    else
    begin
      case (state)
        fdc_pkg::FDC_IDLE:
        begin
          // writes while running never reach here, so they fall away
          if (cmd_wr) // [RULE1] [RULE24] [RULE2]
          begin
            error_flags <= 8'h0; // [RULE23]
            task_out <= task_in; // [RULE3]
            mods <= cmd_byte[3:0];
            retry_cnt <= 3'h0;
            cip <= 1'b1; // [RULE23]
            busy <= 1'b1;
            seek_done <= 1'b0;
            case (cmd_byte[7:4]) // [RULE4]
              fdc_pkg::FDC_OP_RESTORE:
              begin
                op <= fdc_pkg::FDC_OP_RESTORE;
                rate_q <= cmd_byte[3:0]; // [RULE9]
                steps_left <= 11'(RESTORE_STEPS); // [RULE8]
                step_dir_in <= 1'b0;
                state <= fdc_pkg::FDC_STEP;
              end
              fdc_pkg::FDC_OP_SEEK:
              begin
                op <= fdc_pkg::FDC_OP_SEEK;
                rate_q <= cmd_byte[3:0]; // [RULE9]
                state <= fdc_pkg::FDC_CALC;
              end
              fdc_pkg::FDC_OP_READ,
              fdc_pkg::FDC_OP_WRITE:
              begin
                op <= fdc_pkg::fdc_op_t'(cmd_byte[7:4]);
                // refusing before any buffer traffic keeps not-ready and fault
                // errors of a write ahead of the host's data transfer
                if (!drive_ready || drive_fault)
                begin
                  error_flags[`FDC_ER_ABORT] <= 1'b1; // [RULE16]
                  state <= fdc_pkg::FDC_DONE;
                end
                else if (cmd_byte[4])
                begin
                  drq <= 1'b1; // [RULE15]
                  state <= fdc_pkg::FDC_HOST;
                end
                else
                  state <= fdc_pkg::FDC_CALC; // [RULE12]
              end
              fdc_pkg::FDC_OP_SCAN:
              begin
                op <= fdc_pkg::FDC_OP_SCAN;
                state <= fdc_pkg::FDC_SEARCH;
              end
              fdc_pkg::FDC_OP_FORMAT:
              begin
                op <= fdc_pkg::FDC_OP_FORMAT;
                drq <= 1'b1; // [RULE19]
                state <= fdc_pkg::FDC_HOST;
              end
              default:
              begin
                error_flags[`FDC_ER_ABORT] <= 1'b1; // [RULE22]
                state <= fdc_pkg::FDC_DONE;
              end
            endcase
          end
        end
        fdc_pkg::FDC_CALC:
        begin
          // implied or explicit seek: step count is the cylinder gap
          if (task_out.cyl == cur_cyl)
            steps_left <= 11'h0; // [RULE10] [RULE12]
          else if (task_out.cyl > cur_cyl)
          begin
            steps_left <= 11'(task_out.cyl - cur_cyl); // [RULE10]
            step_dir_in <= 1'b1;
          end
          else
          begin
            steps_left <= 11'(cur_cyl - task_out.cyl); // [RULE10]
            step_dir_in <= 1'b0;
          end
          state <= fdc_pkg::FDC_STEP;
        end
        fdc_pkg::FDC_STEP:
        begin
          if (op == fdc_pkg::FDC_OP_RESTORE && track0)
          begin
            cur_cyl <= 10'h0; // [RULE8]
            seek_done <= 1'b1;
            state <= fdc_pkg::FDC_DONE;
          end
          else if (steps_left == 11'h0)
          begin
            if (op == fdc_pkg::FDC_OP_RESTORE)
            begin
              error_flags[`FDC_ER_NOTRK0] <= 1'b1; // [RULE8]
              state <= fdc_pkg::FDC_DONE;
            end
            else if (op == fdc_pkg::FDC_OP_SEEK)
            begin
              seek_done <= 1'b1; // [RULE10]
              state <= fdc_pkg::FDC_DONE;
            end
            else if (op == fdc_pkg::FDC_OP_FORMAT)
            begin
              seek_done <= 1'b1;
              state <= fdc_pkg::FDC_DISK;
            end
            else
            begin
              seek_done <= 1'b1;
              state <= fdc_pkg::FDC_SEARCH; // [RULE12] [RULE15]
            end
          end
          else
          begin
            // every step waits out the saved rate before the next one
            step_pulse <= 1'b1;
            timer_start <= 1'b1; // [RULE5] [RULE9]
            steps_left <= steps_left - 11'h1;
            if (op != fdc_pkg::FDC_OP_RESTORE)
              cur_cyl <= step_dir_in ? cur_cyl + 10'h1 : cur_cyl - 10'h1;
            state <= fdc_pkg::FDC_SETTLE;
          end
        end
        fdc_pkg::FDC_SETTLE:
        begin
          if (timer_done)
            state <= fdc_pkg::FDC_STEP;
        end
        fdc_pkg::FDC_SEARCH:
        begin
          if (id_found && op == fdc_pkg::FDC_OP_SCAN)
          begin
            task_out.head <= id_fields.head; // [RULE17]
            task_out.size <= id_fields.size;
            task_out.sec_num <= id_fields.sec_num;
            task_out.cyl <= id_fields.cyl;
            cur_cyl <= id_fields.cyl; // [RULE17]
            task_update <= 1'b1;
            state <= fdc_pkg::FDC_DONE;
          end
          else if (id_found)
            state <= fdc_pkg::FDC_DISK; // [RULE12] [RULE15]
          else if (id_error)
          begin
            if (op != fdc_pkg::FDC_OP_SCAN && may_retry(mods, retry_cnt))
              retry_cnt <= retry_cnt + 3'h1; // [RULE6]
            else
            begin
              error_flags[`FDC_ER_IDNF] <= 1'b1;
              state <= fdc_pkg::FDC_DONE;
            end
          end
        end
        fdc_pkg::FDC_DISK:
        begin
          if (sector_done && op == fdc_pkg::FDC_OP_READ)
          begin
            // busy drops once the buffer holds the sector
            drq <= 1'b1; // [RULE13]
            busy <= 1'b0;
            if (!mods[`FDC_CMD_IRQ_END])
              ev_irq <= 1'b1; // [RULE7]
            state <= fdc_pkg::FDC_HOST;
          end
          else if (sector_done)
          begin
            task_out.sec_cnt <= task_out.sec_cnt - 8'h1; // [RULE14]
            if (op != fdc_pkg::FDC_OP_FORMAT)
              task_out.sec_num <= task_out.sec_num + 8'h1; // [RULE14]
            task_update <= 1'b1;
            retry_cnt <= 3'h0;
            if (last_sector(op, mods, task_out.sec_cnt))
              state <= fdc_pkg::FDC_DONE; // [RULE15] [RULE20]
            else if (op == fdc_pkg::FDC_OP_FORMAT)
              state <= fdc_pkg::FDC_DISK; // [RULE20]
            else
            begin
              drq <= 1'b1; // next write sector needs fresh data
              state <= fdc_pkg::FDC_HOST;
            end
          end
          // format ignores channel errors altogether
          else if (data_error && op != fdc_pkg::FDC_OP_FORMAT) // [RULE20]
          begin
            if (may_retry(mods, retry_cnt))
            begin
              retry_cnt <= retry_cnt + 3'h1; // [RULE6]
              state <= fdc_pkg::FDC_SEARCH;
            end
            else
            begin
              error_flags[`FDC_ER_DATA] <= 1'b1;
              state <= fdc_pkg::FDC_DONE;
            end
          end
        end
        fdc_pkg::FDC_HOST:
        begin
          if (buffer_ready)
          begin
            drq <= 1'b0;
            busy <= 1'b1;
            if (op == fdc_pkg::FDC_OP_READ)
            begin
              task_out.sec_cnt <= task_out.sec_cnt - 8'h1; // [RULE14]
              task_out.sec_num <= task_out.sec_num + 8'h1; // [RULE14]
              task_update <= 1'b1;
              retry_cnt <= 3'h0;
              if (last_sector(op, mods, task_out.sec_cnt))
                state <= fdc_pkg::FDC_DONE; // [RULE13]
              else
                state <= fdc_pkg::FDC_SEARCH;
            end
            else
              state <= fdc_pkg::FDC_CALC; // [RULE15] [RULE18]
          end
        end
        fdc_pkg::FDC_DONE:
        begin
          cip <= 1'b0; // [RULE23]
          busy <= 1'b0;
          drq <= 1'b0;
          // read with per-sector interrupts has already signalled
          if (op != fdc_pkg::FDC_OP_READ || mods[`FDC_CMD_IRQ_END]
              || error_flags != 8'h0)
            ev_irq <= 1'b1; // [RULE13] [RULE7] [RULE20]
          state <= fdc_pkg::FDC_IDLE;
        end
        default:
          state <= fdc_pkg::FDC_IDLE;
      endcase
    end
  end

  // interrupt flag: a new event wins over an ack in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      disk_irq <= 1'b0;
    else if (ev_irq)
      disk_irq <= 1'b1; // [RULE13] [RULE16]
    else if (disk_interrupt_ack_strobe)
      disk_irq <= 1'b0; // [RULE13]
  end

  // status byte and buffer request, one cycle behind the sequence
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status <= 8'h0;
      buffer_data_request <= 1'b0;
    end
    else
    begin
      status <= 8'h0;
      status[`FDC_ST_ERR] <= |error_flags; // [RULE16] [RULE23]
      status[`FDC_ST_CIP] <= cip; // [RULE23]
      status[`FDC_ST_DRQ] <= drq;
      status[`FDC_ST_SEEKDONE] <= seek_done;
      status[`FDC_ST_FAULT] <= drive_fault;
      status[`FDC_ST_READY] <= drive_ready;
      status[`FDC_ST_BUSY] <= busy;
      buffer_data_request <= drq; // [RULE13] [RULE15]
    end
  end

  // channel requests follow the state by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      chan_req <= '0;
    else
    begin
      chan_req.search <= state == fdc_pkg::FDC_SEARCH;
      chan_req.read <= state == fdc_pkg::FDC_DISK
                       && op == fdc_pkg::FDC_OP_READ;
      chan_req.write <= state == fdc_pkg::FDC_DISK
                        && op == fdc_pkg::FDC_OP_WRITE;
      chan_req.format <= state == fdc_pkg::FDC_DISK
                         && op == fdc_pkg::FDC_OP_FORMAT;
    end
  end

  // lamp select is active low in the control register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      drive_led_on <= 1'b0;
    else
      drive_led_on <= !led_select; // [RULE21]
  end

endmodule : fdc_sequencer

// File: sim/fdc_sequencer_assertions.sv
// assertion checker for the fixed-disk command sequencer
`timescale 1ns/1ps
module fdc_sequencer_checker (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic cmd_wr, // command strobe
  input wire logic [7:0] cmd_byte, // command byte
  input wire logic disk_interrupt_ack_strobe, // ack
  input wire logic led_select, // lamp select
  input wire logic [7:0] status, // status byte
  input wire logic [7:0] error_flags, // error byte
  input wire logic buffer_data_request, // data request
  input wire logic disk_irq, // interrupt
  input wire logic step_pulse, // step
  input wire logic drive_led_on // lamp
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic take;
  logic bad_op;
  // a write is only taken while idle; codes outside the six are undefined
  assign take = cmd_wr & ~status[1];
  assign bad_op = !(cmd_byte[7:4] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7});
  a_cmd_starts: assert property (take |-> ##2 status[1])
    else $error("no start");
  a_abort_code: assert property (take && bad_op |-> ##[1:8] error_flags[2])
    else $error("no abort");
  a_error_clear: assert property (take && !bad_op |-> ##[1:3] !status[0])
    else $error("error kept");
  a_step_gap: assert property (step_pulse |=> !step_pulse [*2])
    else $error("steps too close");
  a_step_busy: assert property (step_pulse |-> status[1])
    else $error("idle step");
  a_led_follow: assert property (1'b1 |=> drive_led_on == !$past(led_select))
    else $error("lamp wrong");
  a_irq_holds: assert property (disk_irq && !disk_interrupt_ack_strobe
    && !cmd_wr |=> disk_irq)
    else $error("irq dropped");
  a_ack_clears: assert property (disk_interrupt_ack_strobe && !status[1]
    |=> !disk_irq)
    else $error("irq kept");
  a_drq_status: assert property ($rose(buffer_data_request) |-> ##[0:2] status[3])
    else $error("drq not in status");
endmodule : fdc_sequencer_checker
bind fdc_sequencer fdc_sequencer_checker u_chk (.*);

// File: sim/fdc_host_model.sv
// host model that issues commands and answers the controller
`timescale 1ns/1ps
module fdc_host_model (
  input wire logic sys_clk, // clock
  input wire logic [7:0] status, // controller status
  output logic cmd_wr = 1'b0, // command strobe
  output logic [7:0] cmd_byte = 8'h00, // command byte
  output fdc_pkg::fdc_task_t task_in = '0, // task file
  output logic buffer_ready = 1'b0, // sector moved
  output logic disk_interrupt_ack_strobe = 1'b0 // interrupt ack
);
  // task file settles with the byte, before the strobe is sampled
  task automatic put_cmd(input logic [7:0] b, input fdc_pkg::fdc_task_t t);
    @(posedge sys_clk);
    #1;
    task_in = t;
    cmd_byte = b;
    cmd_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_wr = 1'b0;
  endtask : put_cmd
  // polite write: only once in-progress and busy are both clear
  task automatic issue(input logic [7:0] b, input fdc_pkg::fdc_task_t t,
                       output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 4000 && !ok; n++)
    begin
      @(posedge sys_clk);
      ok = (status[1] === 1'b0) && (status[7] === 1'b0);
    end
    if (ok)
      put_cmd(b, t);
  endtask : issue
  // one-cycle strobe: 0 buffer moved, 1 interrupt acknowledge
  task automatic strobe(input logic which);
    @(posedge sys_clk);
    #1;
    buffer_ready = !which;
    disk_interrupt_ack_strobe = which;
    @(posedge sys_clk);
    #1;
    buffer_ready = 1'b0;
    disk_interrupt_ack_strobe = 1'b0;
  endtask : strobe
endmodule : fdc_host_model

// File: sim/fdc_sequencer_bench.sv
// self-checking bench for the fixed-disk command sequencer
`timescale 1ns/1ps
module fdc_sequencer_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic led_select = 1'b1;
  logic track0_pin = 1'b1, drive_ready_pin = 1'b1, drive_fault_pin = 1'b0;
  logic id_found = 1'b0, id_error = 1'b0, data_error = 1'b0;
  logic sector_done = 1'b0;
  logic cmd_wr, buffer_ready, ack, drq, irq, step_pulse, dir, led, upd;
  logic last_dir;
  logic [7:0] cmd_byte, status, error_flags;
  logic [11:0] watch;
  fdc_pkg::fdc_task_t task_in, task_out, tf;
  fdc_pkg::fdc_task_t id_fields = '0;
  fdc_pkg::fdc_chan_req_t chan_req;
  int err_total = 0;
  int checks = 0;
  int steps = 0;
  bit ok;
  always #2 sys_clk = ~sys_clk;
  // short step timings keep the run small
  fdc_sequencer #(.STEP_FAST_CYC(3), .STEP_UNIT_CYC(5), .RESTORE_STEPS(8),
    .RETRIES(3)) DUT (.sys_clk, .sys_rst, .cmd_wr, .cmd_byte, .task_in,
    .buffer_ready, .disk_interrupt_ack_strobe(ack), .led_select,
    .track0_pin, .drive_ready_pin, .drive_fault_pin, .id_found, .id_fields,
    .id_error, .sector_done, .data_error, .status, .error_flags,
    .buffer_data_request(drq), .disk_irq(irq), .step_pulse,
    .step_dir_in(dir), .drive_led_on(led), .task_out, .task_update(upd),
    .chan_req);
  fdc_host_model u_host (.sys_clk, .status, .cmd_wr, .cmd_byte, .task_in,
    .buffer_ready, .disk_interrupt_ack_strobe(ack));
  // bits a test may wait on
  assign watch = {chan_req.format, chan_req.search, drq, irq, status};
  // count steps and keep the direction of the last one
  always @(posedge sys_clk)
    if (step_pulse === 1'b1)
    begin
      steps <= steps + 1;
      last_dir <= dir;
    end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_bit(input int b, input logic v);
    int n;
    for (n = 0; n < 3000 && watch[b] !== v; n++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (watch[b] !== v)
    begin
      check(16'(watch[b]), 16'(v));
      end_sim();
    end
  endtask : wait_bit
  task automatic cmd(input logic [7:0] b);
    u_host.issue(b, tf, ok);
    if (!ok)
      wait_bit(1, 1'b0);
  endtask : cmd
  task automatic pulse(ref logic s);
    @(posedge sys_clk);
    #1;
    s = 1'b1;
    @(posedge sys_clk);
    #1;
    s = 1'b0;
  endtask : pulse
  // seek or restore to c; optional intruding write while it runs
  task automatic seek_to(input logic [7:0] b, input logic [9:0] c,
    input int n, input logic d, input bit intr, input logic e);
    int s0;
    s0 = steps;
    tf.cyl = c;
    cmd(b);
    if (intr)
    begin
      wait_bit(1, 1'b1);
      u_host.put_cmd(8'h60, tf);
    end
    wait_bit(8, 1'b1);
    check(16'(steps - s0), 16'(n));
    if (n > 0)
      check(last_dir, d);
    check(status[0], e);
    check(error_flags[2], 1'b0);
    u_host.strobe(1'b1);
    check(irq, 1'b0);
  endtask : seek_to
  // one read sector: id, data, then the host empties the buffer
  task automatic one_sector(input logic irq_want);
    wait_bit(10, 1'b1);
    pulse(id_found);
    pulse(sector_done);
    wait_bit(9, 1'b1);
    @(posedge sys_clk);
    #1;
    check(irq, irq_want);
    u_host.strobe(1'b0);
  endtask : one_sector
  initial
  begin
    tf = '{8'h00, 8'h01, 8'h05, 10'h000, 2'h0, 4'h0};
    repeat (2) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    check(status[1], 1'b0);
    seek_to(8'h10, 10'h000, 0, 1'b0, 0, 1'b0);
    seek_to(8'h70, 10'h005, 5, 1'b1, 0, 1'b0);
    seek_to(8'h71, 10'h002, 3, 1'b0, 1, 1'b0);
    cmd(8'h60);
    wait_bit(8, 1'b1);
    check(error_flags[2], 1'b1);
    check(status[0], 1'b1);
    u_host.strobe(1'b1);
    seek_to(8'h70, 10'h002, 0, 1'b0, 0, 1'b0);
    $display("seek tests done");
    cmd(8'h40);
    wait_bit(10, 1'b1);
    id_fields = '{8'h00, 8'h00, 8'h21, 10'h0c3, 2'h1, 4'h9};
    pulse(id_found);
    wait_bit(8, 1'b1);
    check(task_out.cyl, 10'h0c3);
    check({task_out.head, task_out.sec_num}, 12'h921);
    u_host.strobe(1'b1);
    seek_to(8'h70, 10'h0c5, 2, 1'b1, 0, 1'b0);
    $display("scan test done");
    tf = '{8'h00, 8'h01, 8'h05, 10'h0c5, 2'h0, 4'h0};
    id_fields = tf;
    cmd(8'h20);
    one_sector(1'b1);
    wait_bit(1, 1'b0);
    check(task_out.sec_num, 8'h06);
    u_host.strobe(1'b1);
    tf.sec_cnt = 8'h02;
    cmd(8'h2c);
    one_sector(1'b0);
    one_sector(1'b0);
    wait_bit(8, 1'b1);
    check({task_out.sec_cnt, task_out.sec_num}, 16'h0007);
    u_host.strobe(1'b1);
    $display("read tests done");
    tf.sec_cnt = 8'h01;
    cmd(8'h30);
    wait_bit(9, 1'b1);
    check(chan_req.search, 1'b0);
    u_host.strobe(1'b0);
    wait_bit(10, 1'b1);
    pulse(id_found);
    pulse(sector_done);
    check(chan_req.write, 1'b1);
    wait_bit(8, 1'b1);
    check(status[1], 1'b0);
    u_host.strobe(1'b1);
    tf.sec_cnt = 8'h02;
    cmd(8'h50);
    wait_bit(9, 1'b1);
    u_host.strobe(1'b0);
    repeat (2)
    begin
      wait_bit(11, 1'b1);
      pulse(data_error);
      pulse(sector_done);
    end
    wait_bit(8, 1'b1);
    check(error_flags, 8'h00);
    u_host.strobe(1'b1);
    $display("write tests done");
    led_select = 1'b0;
    track0_pin = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    check(led, 1'b1);
    seek_to(8'h10, 10'h000, 8, 1'b0, 0, 1'b1);
    check(error_flags[1], 1'b1);
    $display("restore test done");
    end_sim();
  end
endmodule : fdc_sequencer_bench
